/* File: hw/pfp_bit.sv */
/*
 * pfp_bit: one flag pin slice: input synchroniser, edge detector,
 * interrupt request latch and registered pad drive.
 * Assumes a single clock and that the owner of the pin drives the
 * acknowledge for one cycle when software clears the latched event.
 */
`timescale 1ns/1ns
module pfp_bit (
   input  wire logic clk_in,
   input  wire logic rstn_in,
   input  wire logic pad_in,        // level seen on the pin
   input  wire logic dir_out_in,    // 1 = pin drives its flag
   input  wire logic flag_in,       // stored output flag
   input  wire logic edge_mode_in,  // 1 = edge, 0 = level
   input  wire logic both_edge_in,  // 1 = both edges count
   input  wire logic ack_in,        // software clear of the event
   input  wire logic alt_en_in,     // pin taken by serial select
   input  wire logic alt_val_in,    // level from serial select
   output logic      pad_out,
   output logic      pad_oe_out,
   output logic      sense_out,
   output logic      pend_out
);

   logic sync1_q;
   logic sync2_q;
   logic prev_q;
   logic latch_q;
   logic src;
   logic hit;

   // two-stage synchroniser; only the second stage reads the first
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= pad_in;
         sync2_q <= sync1_q;
      end
   end

   // event source: the pin for inputs, the written flag for outputs
   assign src = dir_out_in ? flag_in : sync2_q;
   assign hit = (src & ~prev_q)
              | (both_edge_in & ~src & prev_q);

   // previous sample for edge detection
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= src;
      end
   end

   // sticky edge event; a new edge wins over a clear in the same cycle
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         latch_q <= 1'b0;
      end else if (edge_mode_in && hit) begin
         latch_q <= 1'b1;
      end else if (ack_in || !edge_mode_in) begin
         latch_q <= 1'b0;
      end
   end

   // level mode follows the source, edge mode shows the latch
   assign pend_out  = edge_mode_in ? latch_q : src;
   assign sense_out = sync2_q;

   // registered pad drive; serial select takes over when enabled
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pad_out    <= 1'b0;
         pad_oe_out <= 1'b0;
      end else begin
         pad_out    <= alt_en_in ? alt_val_in : flag_in;
         pad_oe_out <= alt_en_in | dir_out_in;
      end
   end

endmodule

/* File: hw/pfp_top.sv */
/*
 * pfp_top: programmable flag port of 48 general-purpose pins with
 * write-one-to-set/clear flags and enables, pin status, per-pin
 * interrupt sensitivity and serial select reuse of eight pins.
 * Assumes a register master that strobes one cycle per access and
 * takes read data in the cycle after the read strobe.
 */
`timescale 1ns/1ns
module pfp_top #(
   parameter int NUM_PINS = pfp_pkg::NUM_PINS
) (
   input  wire logic                         clk_in,
   input  wire logic                         rstn_in,
   input  wire logic [pfp_pkg::ADDR_W-1:0]   reg_addr_in,
   input  wire logic [pfp_pkg::DATA_W-1:0]   reg_wdata_in,
   input  wire logic                         reg_wr_in,
   input  wire logic                         reg_rd_in,
   output logic      [pfp_pkg::DATA_W-1:0]   reg_rdata_out,
   input  wire logic [NUM_PINS-1:0]          gp_flag_pins_all_in,
   output logic      [NUM_PINS-1:0]          gp_flag_pins_all_out,
   output logic      [NUM_PINS-1:0]          gp_flag_pins_all_oe_out,
   input  wire logic [pfp_pkg::NUM_SEL:1]    spi_slave_select_outputs_in,
   output logic                              spi_slave_select_input_out,
   output logic                              irq_out
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [NUM_PINS-1:0]           dir_q;    // 1 = output
   logic [NUM_PINS-1:0]           flag_q;   // stored output flags
   logic [NUM_PINS-1:0]           ien_q;    // interrupt enables
   logic [NUM_PINS-1:0]           sens_q;   // 1 = edge sensitive
   logic [NUM_PINS-1:0]           both_q;   // 1 = both edges
   logic [pfp_pkg::SPI_CTL_W-1:0] spi_q;    // serial select reuse
   logic [pfp_pkg::DATA_W-1:0]    rdata_q;

   logic [NUM_PINS-1:0]           sense;
   logic [NUM_PINS-1:0]           pend;
   logic [NUM_PINS-1:0]           ack;
   logic [NUM_PINS-1:0]           eff_dir;
   logic [NUM_PINS-1:0]           alt_en;
   logic [NUM_PINS-1:0]           alt_val;
   logic [NUM_PINS-1:0]           wide;
   logic [NUM_PINS-1:0]           field;
   logic [pfp_pkg::ADDR_W-1:0]    base;
   logic                          hi_word;
   logic                          ss_sync1_q;
   logic                          ss_sync2_q;

   // ----------------------------------------------------------------
   // write data spread over 48 bits
   // ----------------------------------------------------------------
   // the high word carries pins 47..32 in its low bits; the rest of
   // a high-word write is ignored
   assign hi_word = reg_addr_in[2];
   assign base    = {reg_addr_in[pfp_pkg::ADDR_W-1:3], 3'h0};
   assign wide    = hi_word
                  ? {reg_wdata_in[pfp_pkg::HI_W-1:0], pfp_pkg::WORD_ZERO}
                  : {pfp_pkg::HI_ZERO, reg_wdata_in};
   assign field   = hi_word
                  ? {{pfp_pkg::HI_W{1'b1}}, pfp_pkg::WORD_ZERO}
                  : {pfp_pkg::HI_ZERO, {pfp_pkg::DATA_W{1'b1}}};

   // plain write of the addressed half of a 48-bit register
   function automatic logic [NUM_PINS-1:0] merge(
      input logic [NUM_PINS-1:0] old_v,
      input logic [NUM_PINS-1:0] new_v,
      input logic [NUM_PINS-1:0] sel_v
   );
      merge = (old_v & ~sel_v) | (new_v & sel_v);
   endfunction

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // direction
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dir_q <= pfp_pkg::FLAGS_RST;
      end else if (reg_wr_in && base == pfp_pkg::DIR_LO) begin
         dir_q <= merge(dir_q, wide, field);
      end
   end

   // sensitivity type: level or edge
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sens_q <= pfp_pkg::FLAGS_RST;
      end else if (reg_wr_in && base == pfp_pkg::SENS_LO) begin
         sens_q <= merge(sens_q, wide, field);
      end
   end

   // edge choice: rising only or both
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         both_q <= pfp_pkg::FLAGS_RST;
      end else if (reg_wr_in && base == pfp_pkg::BOTH_LO) begin
         both_q <= merge(both_q, wide, field);
      end
   end

   // serial select reuse control
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         spi_q <= pfp_pkg::SPI_RST;
      end else if (reg_wr_in && reg_addr_in == pfp_pkg::SPI_CTL) begin
         spi_q <= reg_wdata_in[pfp_pkg::SPI_CTL_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // flags and enables: write one to set, write one to clear
   // ----------------------------------------------------------------
   // only bits written as one change; zeros leave the bit alone
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         flag_q <= pfp_pkg::FLAGS_RST;
      end else if (reg_wr_in && base == pfp_pkg::FSET_LO) begin
         flag_q <= flag_q | wide;
      end else if (reg_wr_in && base == pfp_pkg::FCLR_LO) begin
         flag_q <= flag_q & ~wide;
      end
   end

   // interrupt enables
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ien_q <= pfp_pkg::FLAGS_RST;
      end else if (reg_wr_in && base == pfp_pkg::IENS_LO) begin
         ien_q <= ien_q | wide;
      end else if (reg_wr_in && base == pfp_pkg::IENC_LO) begin
         ien_q <= ien_q & ~wide;
      end
   end

   // one-cycle acknowledge of latched edge events
   assign ack = (reg_wr_in && base == pfp_pkg::ICLR_LO)
              ? wide : pfp_pkg::FLAGS_RST;

   // ----------------------------------------------------------------
   // serial select reuse
   // ----------------------------------------------------------------
   // select outputs drive pins 7..1; the select input pin is forced
   // to input while the serial port owns it
   always_comb begin
      alt_en  = pfp_pkg::FLAGS_RST;
      alt_val = pfp_pkg::FLAGS_RST;
      eff_dir = dir_q;
      for (int i = 1; i <= pfp_pkg::NUM_SEL; i++) begin
         alt_en[pfp_pkg::SEL_PIN_LO + i - 1]  = spi_q[i];
         alt_val[pfp_pkg::SEL_PIN_LO + i - 1] =
            spi_slave_select_outputs_in[i];
      end
      if (spi_q[pfp_pkg::SS_IN_BIT]) begin
         eff_dir[pfp_pkg::SS_IN_PIN] = 1'b0;
      end
   end

   // select input level handed to the serial port, idle high when
   // the pin is not reassigned
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ss_sync1_q <= 1'b1;
         ss_sync2_q <= 1'b1;
      end else begin
         ss_sync1_q <= gp_flag_pins_all_in[pfp_pkg::SS_IN_PIN];
         ss_sync2_q <= ss_sync1_q;
      end
   end

   assign spi_slave_select_input_out =
      spi_q[pfp_pkg::SS_IN_BIT] ? ss_sync2_q : 1'b1;

   // ----------------------------------------------------------------
   // pin slices
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      pfp_bit u_bit (
         .clk_in       (clk_in),
         .rstn_in      (rstn_in),
         .pad_in       (gp_flag_pins_all_in[g]),
         .dir_out_in   (eff_dir[g]),
         .flag_in      (flag_q[g]),
         .edge_mode_in (sens_q[g]),
         .both_edge_in (both_q[g]),
         .ack_in       (ack[g]),
         .alt_en_in    (alt_en[g]),
         .alt_val_in   (alt_val[g]),
         .pad_out      (gp_flag_pins_all_out[g]),
         .pad_oe_out   (gp_flag_pins_all_oe_out[g]),
         .sense_out    (sense[g]),
         .pend_out     (pend[g])
      );
   end

   // ----------------------------------------------------------------
   // interrupt
   // ----------------------------------------------------------------
   // level output, high while any enabled request stands
   assign irq_out = |(pend & ien_q);

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // data stand only in the cycle after the read strobe; unmapped and
   // write-only addresses read zero
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_q <= pfp_pkg::WORD_ZERO;
      end else if (!reg_rd_in) begin
         rdata_q <= pfp_pkg::WORD_ZERO;
      end else begin
         unique case (reg_addr_in)
            pfp_pkg::DIR_LO:   rdata_q <= dir_q[pfp_pkg::DATA_W-1:0];
            pfp_pkg::DIR_HI:   rdata_q <= {pfp_pkg::HI_ZERO,
                                  dir_q[NUM_PINS-1:pfp_pkg::DATA_W]};
            pfp_pkg::FSET_LO,
            pfp_pkg::FCLR_LO:  rdata_q <= flag_q[pfp_pkg::DATA_W-1:0];
            pfp_pkg::FSET_HI,
            pfp_pkg::FCLR_HI:  rdata_q <= {pfp_pkg::HI_ZERO,
                                  flag_q[NUM_PINS-1:pfp_pkg::DATA_W]};
            pfp_pkg::FSTAT_LO: rdata_q <= sense[pfp_pkg::DATA_W-1:0];
            pfp_pkg::FSTAT_HI: rdata_q <= {pfp_pkg::HI_ZERO,
                                  sense[NUM_PINS-1:pfp_pkg::DATA_W]};
            pfp_pkg::IENS_LO,
            pfp_pkg::IENC_LO:  rdata_q <= ien_q[pfp_pkg::DATA_W-1:0];
            pfp_pkg::IENS_HI,
            pfp_pkg::IENC_HI:  rdata_q <= {pfp_pkg::HI_ZERO,
                                  ien_q[NUM_PINS-1:pfp_pkg::DATA_W]};
            pfp_pkg::SENS_LO:  rdata_q <= sens_q[pfp_pkg::DATA_W-1:0];
            pfp_pkg::SENS_HI:  rdata_q <= {pfp_pkg::HI_ZERO,
                                  sens_q[NUM_PINS-1:pfp_pkg::DATA_W]};
            pfp_pkg::BOTH_LO:  rdata_q <= both_q[pfp_pkg::DATA_W-1:0];
            pfp_pkg::BOTH_HI:  rdata_q <= {pfp_pkg::HI_ZERO,
                                  both_q[NUM_PINS-1:pfp_pkg::DATA_W]};
            pfp_pkg::ISTAT_LO: rdata_q <= pend[pfp_pkg::DATA_W-1:0];
            pfp_pkg::ISTAT_HI: rdata_q <= {pfp_pkg::HI_ZERO,
                                  pend[NUM_PINS-1:pfp_pkg::DATA_W]};
            pfp_pkg::SPI_CTL:  rdata_q <= {{(pfp_pkg::DATA_W -
                                  pfp_pkg::SPI_CTL_W){1'b0}}, spi_q};
            default:           rdata_q <= pfp_pkg::WORD_ZERO;
         endcase
      end
   end

   assign reg_rdata_out = rdata_q;

endmodule

/* File: shared/pfp_pkg.sv */
/*
 * pfp_pkg: register map, field layout, reset values and sizes of the
 * programmable flag port.
 * Assumes a 32-bit register port with byte addresses; each 48-bit flag
 * register takes a low word (bits 31..0) and a high word (bits 47..32).
 */
package pfp_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int NUM_PINS    = 48;
   localparam int DATA_W      = 32;
   localparam int HI_W        = NUM_PINS - DATA_W;
   localparam int ADDR_W      = 8;
   localparam int NUM_SEL     = 7;

   // ----------------------------------------------------------------
   // register byte addresses; high word of a pair sits at base + 4
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] DIR_LO   = 8'h00;
   localparam logic [ADDR_W-1:0] DIR_HI   = 8'h04;
   localparam logic [ADDR_W-1:0] FSET_LO  = 8'h08;
   localparam logic [ADDR_W-1:0] FSET_HI  = 8'h0C;
   localparam logic [ADDR_W-1:0] FCLR_LO  = 8'h10;
   localparam logic [ADDR_W-1:0] FCLR_HI  = 8'h14;
   localparam logic [ADDR_W-1:0] FSTAT_LO = 8'h18;
   localparam logic [ADDR_W-1:0] FSTAT_HI = 8'h1C;
   localparam logic [ADDR_W-1:0] IENS_LO  = 8'h20;
   localparam logic [ADDR_W-1:0] IENS_HI  = 8'h24;
   localparam logic [ADDR_W-1:0] IENC_LO  = 8'h28;
   localparam logic [ADDR_W-1:0] IENC_HI  = 8'h2C;
   localparam logic [ADDR_W-1:0] SENS_LO  = 8'h30;
   localparam logic [ADDR_W-1:0] SENS_HI  = 8'h34;
   localparam logic [ADDR_W-1:0] BOTH_LO  = 8'h38;
   localparam logic [ADDR_W-1:0] BOTH_HI  = 8'h3C;
   localparam logic [ADDR_W-1:0] ISTAT_LO = 8'h40;
   localparam logic [ADDR_W-1:0] ISTAT_HI = 8'h44;
   localparam logic [ADDR_W-1:0] ICLR_LO  = 8'h48;
   localparam logic [ADDR_W-1:0] ICLR_HI  = 8'h4C;
   localparam logic [ADDR_W-1:0] SPI_CTL  = 8'h50;

   // ----------------------------------------------------------------
   // serial select reuse: control bit 0 = select input, 7..1 = outputs
   // ----------------------------------------------------------------
   localparam int SS_IN_BIT   = 0;
   localparam int SS_IN_PIN   = 0;
   localparam int SEL_PIN_LO  = 1;
   localparam int SPI_CTL_W   = 8;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [NUM_PINS-1:0]  FLAGS_RST = 48'h0000_0000_0000;
   localparam logic [DATA_W-1:0]    WORD_ZERO = 32'h0000_0000;
   localparam logic [HI_W-1:0]      HI_ZERO   = 16'h0000;
   localparam logic [SPI_CTL_W-1:0] SPI_RST   = 8'h00;

endpackage

/* File: testbench/pfp_checker.sv */
/* pfp_checker: port assertions for pfp_top.
   assumes one clock, async active-low reset; bound below by name. */
`timescale 1ns/1ns
module pfp_checker #(
   parameter int NUM_PINS = 48
) (
   input wire logic                       clk_in,
   input wire logic                       rstn_in,
   input wire logic [pfp_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [pfp_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic                       reg_wr_in,
   input wire logic                       reg_rd_in,
   input wire logic [pfp_pkg::DATA_W-1:0] reg_rdata_out,
   input wire logic [NUM_PINS-1:0]        gp_flag_pins_all_in,
   input wire logic [NUM_PINS-1:0]        gp_flag_pins_all_out,
   input wire logic [NUM_PINS-1:0]        gp_flag_pins_all_oe_out,
   input wire logic [pfp_pkg::NUM_SEL:1]  spi_slave_select_outputs_in,
   input wire logic                       spi_slave_select_input_out,
   input wire logic                       irq_out
);
   // ----------------------------------------------------------------
   // helper state
   // ----------------------------------------------------------------
   logic [NUM_PINS-1:0] en_q;    // enables as software left them
   logic [NUM_PINS-1:0] pin_q;   // previous pin sample
   logic [2:0]          pstab_q; // cycles the pins held still
   logic [7:0]          spi_q;   // copy of serial reuse control
   logic                wr_cfg;  // write that may move pin drivers
   logic [31:0]         stat_w;  // status word the pins imply
   wire logic [7:0]     a = reg_addr_in;

   // combinational views of the current request
   assign wr_cfg = reg_wr_in && (a == pfp_pkg::DIR_LO ||
      a == pfp_pkg::DIR_HI || a == pfp_pkg::SPI_CTL);
   assign stat_w = (a == pfp_pkg::FSTAT_LO) ? gp_flag_pins_all_in[31:0]
      : {16'h0000, gp_flag_pins_all_in[NUM_PINS-1:32]};

   // track enables and serial reuse from register writes
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         en_q  <= '0;
         spi_q <= 8'h00;
      end else if (reg_wr_in) begin
         case (a)
            pfp_pkg::IENS_LO: en_q[31:0] <= en_q[31:0] | reg_wdata_in;
            pfp_pkg::IENS_HI: en_q[47:32] <= en_q[47:32] | reg_wdata_in[15:0];
            pfp_pkg::IENC_LO: en_q[31:0] <= en_q[31:0] & ~reg_wdata_in;
            pfp_pkg::IENC_HI: en_q[47:32] <= en_q[47:32] & ~reg_wdata_in[15:0];
            pfp_pkg::SPI_CTL: spi_q <= reg_wdata_in[7:0];
            default: ;
         endcase
      end
   end

   // count how long the pins have been still
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_q   <= '0;
         pstab_q <= 3'd0;
      end else begin
         pin_q   <= gp_flag_pins_all_in;
         pstab_q <= (gp_flag_pins_all_in != pin_q) ? 3'd0 :
                    (pstab_q == 3'd7) ? 3'd7 : pstab_q + 3'd1;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_set8;
      reg_wr_in && a == pfp_pkg::FSET_LO && reg_wdata_in[8];
   endsequence
   sequence s_clr8;
      reg_wr_in && a == pfp_pkg::FCLR_LO && reg_wdata_in[8];
   endsequence

   AST_SET_DRIVE: assert property (s_set8 |-> ##2
      (!gp_flag_pins_all_oe_out[8] || gp_flag_pins_all_out[8]))
      else $error("set write did not raise pin 8");
   AST_CLR_DRIVE: assert property (s_clr8 |-> ##2
      (!gp_flag_pins_all_oe_out[8] || !gp_flag_pins_all_out[8]))
      else $error("clear write did not lower pin 8");
   AST_OE_CAUSE: assert property ($changed(gp_flag_pins_all_oe_out) |->
      $past(wr_cfg) || $past(wr_cfg, 2) || $past(wr_cfg, 3))
      else $error("pin enable moved without a direction write");
   AST_SEL_OUT: assert property (&spi_q[7:1] && $past(&spi_q[7:1]) |->
      gp_flag_pins_all_out[7:1] == $past(spi_slave_select_outputs_in)
      && &gp_flag_pins_all_oe_out[7:1])
      else $error("select outputs not driven from serial engine");
   AST_SS_IDLE: assert property (!spi_q[0] && !$past(spi_q[0]) |->
      spi_slave_select_input_out)
      else $error("select input low while not reassigned");
   AST_STAT_READ: assert property (reg_rd_in && pstab_q >= 3'd4 &&
      (a == pfp_pkg::FSTAT_LO || a == pfp_pkg::FSTAT_HI)
      |=> reg_rdata_out == $past(stat_w))
      else $error("status read differs from pin levels");
   AST_RD_IDLE: assert property (!$past(reg_rd_in) |->
      reg_rdata_out == 32'h0000_0000)
      else $error("read data outside the answer cycle");
   AST_UNMAPPED: assert property (reg_rd_in && a > pfp_pkg::SPI_CTL
      |=> reg_rdata_out == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_IRQ_GATE: assert property (irq_out |-> en_q != '0)
      else $error("interrupt with every enable off");
endmodule

bind pfp_top pfp_checker #(.NUM_PINS(NUM_PINS)) u_chk (
   .clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .gp_flag_pins_all_in(gp_flag_pins_all_in),
   .gp_flag_pins_all_out(gp_flag_pins_all_out),
   .gp_flag_pins_all_oe_out(gp_flag_pins_all_oe_out),
   .spi_slave_select_outputs_in(spi_slave_select_outputs_in),
   .spi_slave_select_input_out(spi_slave_select_input_out),
   .irq_out(irq_out));

/* File: testbench/pfp_pins.sv */
/* pfp_pins: outside devices on the flag pins.
   assumes the bench sets the level each device applies. */
`timescale 1ns/1ns
module pfp_pins #(
   parameter int NUM_PINS = 48
) (
   input  wire logic [NUM_PINS-1:0] drv_in,  // level the block drives
   input  wire logic [NUM_PINS-1:0] oe_in,   // block drives the pin
   input  wire logic [NUM_PINS-1:0] ext_in,  // level devices apply
   output logic      [NUM_PINS-1:0] pad_out  // resolved wire level
);
   // a driven pin carries the block's level, a released one the device's
   assign pad_out = (oe_in & drv_in) | (~oe_in & ext_in);
endmodule

/* File: testbench/tb_programmable_flag_port.sv */
/* tb_programmable_flag_port: register-level tests of pfp_top.
   assumes a 50 MHz clock and the pin model pfp_pins. */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
   err_total++; $display("wrong value %s expected %h seen %h", nm, ex, got); \
   end end
module tb_programmable_flag_port;
   logic clk_in, rstn_in, wr_s, rd_s, ss_in, irq;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic [47:0] pins, pout, oe, ext;
   logic [7:1]  sel;
   int          err_total = 0;
   int          compares = 0;

   pfp_top dut (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
      .reg_rdata_out(rdata), .gp_flag_pins_all_in(pins),
      .gp_flag_pins_all_out(pout), .gp_flag_pins_all_oe_out(oe),
      .spi_slave_select_outputs_in(sel),
      .spi_slave_select_input_out(ss_in), .irq_out(irq));
   pfp_pins u_pins (.drv_in(pout), .oe_in(oe), .ext_in(ext), .pad_out(pins));

   // ----------------------------------------------------------------
   // clock, access tasks and verdict
   // ----------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk_in);
      wr_s  <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      @(posedge clk_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_in);
      rd_s <= 1'b0;
      @(negedge clk_in);
      `CHK("rdata", ex, rdata)
   endtask

   // move one input pin, then look at pending bits and the interrupt
   task automatic step(input int i, input logic v, input logic [31:0] ex,
                       input logic ir);
      @(posedge clk_in);
      ext[i] <= v;
      repeat (5) @(posedge clk_in);
      rd(pfp_pkg::ISTAT_LO, ex);
      `CHK("irq", ir, irq)
   endtask

   task automatic give_verdict();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      repeat (5000) @(posedge clk_in);
      err_total++;
      give_verdict();
   end

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      {rstn_in, wr_s, rd_s, addr, wdata, ext, sel} = '0;
      repeat (16) @(posedge clk_in);
      rstn_in <= 1'b1;
      for (int a = 0; a <= 'h54; a += 4) begin
         rd(8'(a), 32'h0000_0000);
      end
      `CHK("ss_in", 1'b1, ss_in)
      `CHK("oe", 48'h0000_0000_0000, oe)
      // output flags: set and clear without touching neighbours
      wr(pfp_pkg::DIR_LO, 32'hFFFF_FFFF);
      wr(pfp_pkg::DIR_HI, 32'h0000_FFFF);
      wr(pfp_pkg::FSET_LO, 32'h0000_8101);
      wr(pfp_pkg::FSET_LO, 32'h0000_0010);
      wr(pfp_pkg::FCLR_LO, 32'h0000_0100);
      wr(pfp_pkg::FSET_HI, 32'hFFFF_8001);
      repeat (4) @(posedge clk_in);
      rd(pfp_pkg::FSTAT_LO, 32'h0000_8011);
      rd(pfp_pkg::FSTAT_HI, 32'h0000_8001);
      rd(pfp_pkg::FSET_LO, 32'h0000_8011);
      `CHK("oe", 48'hFFFF_FFFF_FFFF, oe)
      // input interrupts: rising, both edges, level, masking
      wr(pfp_pkg::DIR_LO, 32'h0000_0000);
      wr(pfp_pkg::DIR_HI, 32'h0000_0000);
      wr(pfp_pkg::SENS_LO, 32'h0000_0160);
      wr(pfp_pkg::BOTH_LO, 32'h0000_0040);
      wr(pfp_pkg::IENS_LO, 32'h0000_01E0);
      repeat (4) @(posedge clk_in);
      wr(pfp_pkg::ICLR_LO, 32'hFFFF_FFFF);
      step(5, 1'b1, 32'h0000_0020, 1'b1);
      wr(pfp_pkg::ICLR_LO, 32'h0000_0020);
      step(5, 1'b0, 32'h0000_0000, 1'b0);
      step(6, 1'b1, 32'h0000_0040, 1'b1);
      wr(pfp_pkg::ICLR_LO, 32'h0000_0040);
      step(6, 1'b0, 32'h0000_0040, 1'b1);
      wr(pfp_pkg::ICLR_LO, 32'h0000_0040);
      step(7, 1'b1, 32'h0000_0080, 1'b1);
      wr(pfp_pkg::ICLR_LO, 32'h0000_0080);
      rd(pfp_pkg::ISTAT_LO, 32'h0000_0080);
      step(7, 1'b0, 32'h0000_0000, 1'b0);
      wr(pfp_pkg::IENC_LO, 32'h0000_0020);
      step(5, 1'b1, 32'h0000_0020, 1'b0);
      wr(pfp_pkg::IENS_LO, 32'h0000_0020);
      @(negedge clk_in);
      `CHK("irq", 1'b1, irq)
      wr(pfp_pkg::ICLR_LO, 32'h0000_0020);
      rd(pfp_pkg::ISTAT_LO, 32'h0000_0000);
      // software interrupt from an output flag
      wr(pfp_pkg::DIR_LO, 32'h0000_0100);
      wr(pfp_pkg::ICLR_LO, 32'hFFFF_FFFF);
      wr(pfp_pkg::FSET_LO, 32'h0000_0100);
      repeat (3) @(posedge clk_in);
      rd(pfp_pkg::ISTAT_LO, 32'h0000_0100);
      `CHK("irq", 1'b1, irq)
      // serial select reuse of pins 7..0
      sel <= 7'h55;
      wr(pfp_pkg::SPI_CTL, 32'h0000_00FF);
      repeat (4) @(posedge clk_in);
      @(negedge clk_in);
      `CHK("sel_out", 7'h55, pout[7:1])
      `CHK("sel_oe", 7'h7F, oe[7:1])
      `CHK("ss_in", 1'b0, ss_in)
      @(posedge clk_in);
      ext[0] <= 1'b1;
      repeat (5) @(posedge clk_in);
      @(negedge clk_in);
      `CHK("ss_in", 1'b1, ss_in)
      wr(pfp_pkg::SPI_CTL, 32'h0000_0000);
      repeat (3) @(posedge clk_in);
      give_verdict();
   end
endmodule
